// [design/spmgt_pkg.sv]
/*
 * spmgt_pkg: constants and types shared by the power and system
 * management block. Assumes a 100 MHz system clock.
 */
package spmgt_pkg;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int BTN_MIN_MS = 16;
    // least time rounds up; qualify at three quarters of 16 ms (12 ms) for margin
    localparam int BTN_QUAL_CYC = (BTN_MIN_MS * 1000 * CLK_MHZ) * 3 / 4;
    localparam int RST_PULSE_US = 1;
    localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
    localparam int WARN_US = 1;
    localparam int WARN_CYC = WARN_US * CLK_MHZ;
    localparam int PWM_WIDTH = 8;
    localparam int TACH_PULSES_PER_REV = 2;
    localparam int SYNC_STAGES = 3;
    // ==========================================================
    // power states
    typedef enum logic [2:0] {
        SPMGT_S0,
        SPMGT_WARN3,
        SPMGT_S3,
        SPMGT_WARN5,
        SPMGT_S5
    } spmgt_state_t;
    // ==========================================================
    // debounced button events
    typedef struct packed {
        logic power;
        logic reset;
        logic lid;
        logic doze;
    } spmgt_btn_t;
    // level inputs, active high after inversion
    typedef struct packed {
        logic supply_good;
        logic pcie_wake;
        logic general_wake;
        logic battery_low;
        logic overtemp;
        logic bus_alert;
        logic tach;
    } spmgt_lvl_t;
endpackage : spmgt_pkg

// [design/spmgt_sync.sv]
/*
 * spmgt_sync: three-flop synchroniser; output changes once stages two
 * and three agree. Assumes the input is asynchronous to mclk_i.
 */
`timescale 1ns/1ps
module spmgt_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic mclk_i, // system clock
    input wire logic rst_i,  // sync reset, high
    input wire logic d_i,    // async input
    output logic q_o         // synchronised level
);
    logic s1;
    logic s2;
    logic s3;
    // ==========================================================
    // stages
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q_o <= INIT;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s2;
            end
        end
    end
endmodule : spmgt_sync

// [design/spmgt_debounce.sv]
/*
 * spmgt_debounce: qualifies an active-low synchronised button; emits a
 * one-cycle press pulse once held low for QUAL_CYC cycles.
 * Assumes the input is already synchronised.
 */
`timescale 1ns/1ps
module spmgt_debounce #(
    parameter int QUAL_CYC = spmgt_pkg::BTN_QUAL_CYC
) (
    input wire logic mclk_i, // system clock
    input wire logic rst_i,  // sync reset, high
    input wire logic btn_n_i,// synchronised button, low pressed
    output logic press_o     // one-cycle press pulse
);
    localparam int CW = $clog2(QUAL_CYC + 1);
    logic [CW-1:0] cnt;
    logic taken;
    wire logic hit = (cnt == CW'(QUAL_CYC - 1));
    if (QUAL_CYC < 1) begin : g_bad_qual
        $error("QUAL_CYC must be at least 1");
    end
    // ==========================================================
    // qualify the low pulse, fire once per press
    always_ff @(posedge mclk_i) begin
        if (rst_i || btn_n_i) begin
            cnt <= '0;
            taken <= 1'b0;
            press_o <= 1'b0;
        end else begin
            press_o <= hit && !taken;
            if (hit) begin
                taken <= 1'b1;
            end else if (!taken) begin
                cnt <= cnt + CW'(1);
            end
        end
    end
    property p_once;
        @(posedge mclk_i) disable iff (rst_i)
        press_o |=> !press_o;
    endproperty
    a_once: assert property (p_once)
        else $error("press pulse too long");
endmodule : spmgt_debounce

// [design/spmgt_top.sv]
/*
 * spmgt_top: power and system management logic of the module. Takes the
 * carrier buttons, supply-good and sensor inputs; drives carrier reset,
 * suspend indicators, watchdog, thermal shutdown and fan PWM.
 * Assumes all pin inputs are asynchronous and pulled high when idle.
 */
`timescale 1ns/1ps
//
// Operation
// - falling edge on power button leaves soft-off; code leaves S5 on the button only after it is held low QUAL_CYC cycles, or on a wake input.
// - buttons held low 16 ms are reliably recognised.
// - reset button is edge triggered; holding it low does not hold reset.
// - carrier reset low on button, bad supply, low input, watchdog, software.
// - supply-good high means power good.
// - suspend warning asserted before entering low power state.
// - suspend-to-RAM output low while in S3.
// - shared disk/soft-off output low in S4 or S5.
// - low PCIe wake input wakes from sleep.
// - low general wake input is a wake event.
// - low battery input is registered.
// - doze button presses reported to software.
// - cover switch activity reported as lid event.
// - watchdog indicator asserted after watchdog time-out.
// - low over-temperature input is an over-temperature condition.
// - thermal shutdown output low once processor is in thermal shutdown.
// - low bus alert raises system management interrupt.
// - fan PWM duty cycle sets fan speed.
// - tach counted at two pulses per revolution.
module spmgt_top #(
    parameter int QUAL_CYC = spmgt_pkg::BTN_QUAL_CYC,
    parameter int PWM_W = spmgt_pkg::PWM_WIDTH,
    parameter int REV_W = 16
) (
    input wire logic mclk_i,                  // 100 MHz clock
    input wire logic rst_i,                   // sync reset, high
    input wire logic power_button_n_i,        // power button, low
    input wire logic reset_button_n_i,        // reset button, low
    input wire logic lid_button_n_i,          // cover switch, low
    input wire logic doze_button_n_i,         // sleep button, low
    input wire logic supply_good_i,           // supply good, high
    input wire logic vin_low_i,               // main input under min
    input wire logic pcie_wake_request_n_i,   // pcie wake, low
    input wire logic general_wake_request_n_i,// general wake, low
    input wire logic battery_low_n_i,         // battery low, low
    input wire logic overtemp_in_n_i,         // over-temp sensor, low
    input wire logic sysmgmt_bus_alert_n_i,   // bus alert, low
    input wire logic fan_speed_sense_i,       // tachometer
    input wire logic watchdog_timeout_i,      // watchdog event pulse
    input wire logic sw_reset_req_i,          // software reset pulse
    input wire logic sw_sleep_ram_i,          // request S3 pulse
    input wire logic sw_soft_off_i,           // request S5 pulse
    input wire logic cpu_thermal_trip_i,      // cpu in thermal shutdown
    input wire logic event_clear_i,           // clear sticky events
    input wire logic [PWM_W-1:0] fan_duty_i,  // fan duty
    output logic carrier_reset_out_n_o,       // carrier reset, low
    output logic suspend_warning_n_o,         // suspend warning, low
    output logic suspend_ram_n_o,             // S3 indicator, low
    output logic suspend_disk_n_o,            // S4/S5 indicator, low
    output logic soft_off_n_o,                // same as disk
    output logic watchdog_expired_out_o,      // watchdog indicator
    output logic thermal_shutdown_out_n_o,    // thermal shutdown, low
    output logic system_mgmt_interrupt_n_o,   // smi, low
    output logic fan_drive_pwm_o,             // fan pwm
    output logic lid_event_o,                 // sticky lid event
    output logic doze_event_o,                // sticky doze event
    output logic battery_low_o,               // sticky battery low
    output logic overtemp_o,                  // over-temp level
    output logic wake_event_o,                // sticky wake event
    output logic [REV_W-1:0] fan_revs_o       // fan revolutions
);
    if (PWM_W < 2 || REV_W < 2) begin : g_bad_width
        $error("widths too small");
    end
    // ==========================================================
    // synchronisers
    spmgt_pkg::spmgt_btn_t btn_s;
    spmgt_pkg::spmgt_btn_t press;
    spmgt_pkg::spmgt_lvl_t lvl_s;
    logic [10:0] raw;
    logic [10:0] syn;
    assign raw = {power_button_n_i, reset_button_n_i, lid_button_n_i,
                  doze_button_n_i, supply_good_i, pcie_wake_request_n_i,
                  general_wake_request_n_i, battery_low_n_i,
                  overtemp_in_n_i, sysmgmt_bus_alert_n_i,
                  fan_speed_sense_i};
    for (genvar g = 0; g < 11; g++) begin : g_sync
        spmgt_sync #(.INIT(1'b1)) u_sync (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .d_i(raw[g]),
            .q_o(syn[g])
        );
    end
    assign btn_s = syn[10:7];
    assign lvl_s.supply_good = syn[6];
    assign lvl_s.pcie_wake = !syn[5];
    assign lvl_s.general_wake = !syn[4];
    assign lvl_s.battery_low = !syn[3];
    assign lvl_s.overtemp = !syn[2];
    assign lvl_s.bus_alert = !syn[1];
    assign lvl_s.tach = syn[0];
    // ==========================================================
    // button qualification
    spmgt_debounce #(.QUAL_CYC(QUAL_CYC)) u_db_pwr (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .btn_n_i(btn_s.power), .press_o(press.power));
    spmgt_debounce #(.QUAL_CYC(QUAL_CYC)) u_db_rst (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .btn_n_i(btn_s.reset), .press_o(press.reset));
    spmgt_debounce #(.QUAL_CYC(QUAL_CYC)) u_db_lid (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .btn_n_i(btn_s.lid), .press_o(press.lid));
    spmgt_debounce #(.QUAL_CYC(QUAL_CYC)) u_db_doze (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .btn_n_i(btn_s.doze), .press_o(press.doze));
    // ==========================================================
    // power state machine
    localparam int WW = $clog2(spmgt_pkg::WARN_CYC + 1);
    spmgt_pkg::spmgt_state_t state;
    spmgt_pkg::spmgt_state_t next_state;
    logic [WW-1:0] warn_cnt;
    wire logic wake_any = lvl_s.pcie_wake || lvl_s.general_wake;
    wire logic warn_done = (warn_cnt == WW'(spmgt_pkg::WARN_CYC - 1));
    wire logic in_warn = (state == spmgt_pkg::SPMGT_WARN3) ||
                         (state == spmgt_pkg::SPMGT_WARN5);
    always_comb begin
        next_state = state;
        case (state)
            spmgt_pkg::SPMGT_S0: begin
                if (sw_soft_off_i) begin
                    next_state = spmgt_pkg::SPMGT_WARN5;
                end else if (sw_sleep_ram_i || press.doze) begin
                    next_state = spmgt_pkg::SPMGT_WARN3;
                end
            end
            spmgt_pkg::SPMGT_WARN3: begin
                if (warn_done) next_state = spmgt_pkg::SPMGT_S3;
            end
            spmgt_pkg::SPMGT_WARN5: begin
                if (warn_done) next_state = spmgt_pkg::SPMGT_S5;
            end
            spmgt_pkg::SPMGT_S3: begin
                if (wake_any || press.power || press.doze) begin
                    next_state = spmgt_pkg::SPMGT_S0;
                end
            end
            spmgt_pkg::SPMGT_S5: begin
                if (press.power || wake_any) begin
                    next_state = spmgt_pkg::SPMGT_S0;
                end
            end
            default: next_state = spmgt_pkg::SPMGT_S0;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= spmgt_pkg::SPMGT_S5;
            warn_cnt <= '0;
        end else begin
            state <= next_state;
            warn_cnt <= in_warn ? warn_cnt + WW'(1) : '0;
        end
    end
    // ==========================================================
    // carrier reset: a taken reset press yields a fixed pulse
    localparam int RW = $clog2(spmgt_pkg::RST_PULSE_CYC + 1);
    logic [RW-1:0] rst_cnt;
    logic wdt_flag;
    wire logic rst_pulse = (rst_cnt != '0);
    wire logic rst_cause = rst_pulse || !lvl_s.supply_good ||
                           vin_low_i || watchdog_timeout_i ||
                           sw_reset_req_i;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rst_cnt <= '0;
        end else if (press.reset || watchdog_timeout_i) begin
            rst_cnt <= RW'(spmgt_pkg::RST_PULSE_CYC);
        end else if (rst_pulse) begin
            rst_cnt <= rst_cnt - RW'(1);
        end
    end
    // ==========================================================
    // outputs and sticky events (set wins over clear)
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            carrier_reset_out_n_o <= 1'b0;
            suspend_warning_n_o <= 1'b0;
            suspend_ram_n_o <= 1'b1;
            suspend_disk_n_o <= 1'b0;
            soft_off_n_o <= 1'b0;
            wdt_flag <= 1'b0;
            thermal_shutdown_out_n_o <= 1'b1;
            system_mgmt_interrupt_n_o <= 1'b1;
            lid_event_o <= 1'b0;
            doze_event_o <= 1'b0;
            battery_low_o <= 1'b0;
            overtemp_o <= 1'b0;
            wake_event_o <= 1'b0;
        end else begin
            carrier_reset_out_n_o <= !(rst_cause ||
                                       state != spmgt_pkg::SPMGT_S0);
            suspend_warning_n_o <= (state == spmgt_pkg::SPMGT_S0) &&
                                   (next_state == spmgt_pkg::SPMGT_S0);
            suspend_ram_n_o <= (next_state != spmgt_pkg::SPMGT_S3);
            suspend_disk_n_o <= (next_state != spmgt_pkg::SPMGT_S5);
            soft_off_n_o <= (next_state != spmgt_pkg::SPMGT_S5);
            wdt_flag <= watchdog_timeout_i ||
                        (wdt_flag && !event_clear_i);
            thermal_shutdown_out_n_o <= !cpu_thermal_trip_i;
            system_mgmt_interrupt_n_o <= !lvl_s.bus_alert;
            lid_event_o <= press.lid || (lid_event_o && !event_clear_i);
            doze_event_o <= press.doze ||
                            (doze_event_o && !event_clear_i);
            battery_low_o <= lvl_s.battery_low ||
                             (battery_low_o && !event_clear_i);
            overtemp_o <= lvl_s.overtemp;
            wake_event_o <= wake_any || (wake_event_o && !event_clear_i);
        end
    end
    assign watchdog_expired_out_o = wdt_flag;
    // ==========================================================
    // fan pwm and tachometer
    logic [PWM_W-1:0] pwm_cnt;
    logic tach_d;
    logic half_rev;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pwm_cnt <= '0;
            fan_drive_pwm_o <= 1'b0;
            tach_d <= 1'b1;
            half_rev <= 1'b0;
            fan_revs_o <= '0;
        end else begin
            pwm_cnt <= pwm_cnt + PWM_W'(1);
            fan_drive_pwm_o <= (pwm_cnt < fan_duty_i);
            tach_d <= lvl_s.tach;
            if (lvl_s.tach && !tach_d) begin
                half_rev <= !half_rev;
                if (half_rev) fan_revs_o <= fan_revs_o + REV_W'(1);
            end
        end
    end
    // ==========================================================
    // checks
    property p_s3_out;
        @(posedge mclk_i) disable iff (rst_i)
        (state == spmgt_pkg::SPMGT_S3) |-> !suspend_ram_n_o;
    endproperty
    a_s3_out: assert property (p_s3_out)
        else $error("S3 output not low");
    property p_s5_out;
        @(posedge mclk_i) disable iff (rst_i)
        (state == spmgt_pkg::SPMGT_S5) |-> !suspend_disk_n_o && !soft_off_n_o;
    endproperty
    a_s5_out: assert property (p_s5_out)
        else $error("S5 output not low");
    property p_warn;
        @(posedge mclk_i) disable iff (rst_i)
        in_warn |-> !suspend_warning_n_o;
    endproperty
    a_warn: assert property (p_warn)
        else $error("no suspend warning");
    property p_pwr_wake;
        @(posedge mclk_i) disable iff (rst_i)
        (state == spmgt_pkg::SPMGT_S5 && press.power)
        |=> state == spmgt_pkg::SPMGT_S0;
    endproperty
    a_pwr_wake: assert property (p_pwr_wake)
        else $error("no power-on");
    property p_supply;
        @(posedge mclk_i) disable iff (rst_i)
        !lvl_s.supply_good |=> !carrier_reset_out_n_o;
    endproperty
    a_supply: assert property (p_supply)
        else $error("reset not driven");
    property p_wdt;
        @(posedge mclk_i) disable iff (rst_i)
        watchdog_timeout_i |=> watchdog_expired_out_o;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog flag missing");
    property p_smi;
        @(posedge mclk_i) disable iff (rst_i)
        lvl_s.bus_alert |=> !system_mgmt_interrupt_n_o;
    endproperty
    a_smi: assert property (p_smi)
        else $error("smi not raised");
    property p_trip;
        @(posedge mclk_i) disable iff (rst_i)
        cpu_thermal_trip_i |=> !thermal_shutdown_out_n_o;
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip not shown");
    property p_pwm_off;
        @(posedge mclk_i) disable iff (rst_i)
        (fan_duty_i == '0) && $stable(fan_duty_i) |=> !fan_drive_pwm_o;
    endproperty
    a_pwm_off: assert property (p_pwm_off)
        else $error("pwm on at 0");
    // leaving S0: warning goes low while both sleep outputs still stand high
    sequence s_sleep_req;
        (state == spmgt_pkg::SPMGT_S0) &&
        (next_state != spmgt_pkg::SPMGT_S0);
    endsequence
    sequence s_warned;
        !suspend_warning_n_o && suspend_ram_n_o && suspend_disk_n_o;
    endsequence
    property p_warn_lead;
        @(posedge mclk_i) disable iff (rst_i)
        s_sleep_req |=> s_warned;
    endproperty
    a_warn_lead: assert property (p_warn_lead)
        else $error("warning does not lead sleep");
endmodule : spmgt_top

// [verif/spmgt_carrier.sv]
/*
 * spmgt_carrier: carrier-side model of buttons, supply, sensors and fan
 * tachometer. Assumes mclk_i is the bench clock; lines change at its
 * falling edge and released lines rest at their pull-up level.
 */
`timescale 1ns/1ps
module spmgt_carrier (
    input wire logic mclk_i,   // bench clock
    output logic [9:0] pin_n_o,// button, supply and sensor lines
    output logic tach_o        // fan tachometer
);
    // ==========================================================
    // line levels
    logic [9:0] act;
    // asserted lines go low, released ones return high
    assign pin_n_o = ~act;
    initial begin
        act = 10'h000;
        tach_o = 1'h1;
    end
    task automatic set_pin(input int i, input logic v);
        @(negedge mclk_i);
        act[i] = v;
    endtask : set_pin
    // button held low for a counted number of cycles
    task automatic hold(input int i, input int cyc);
        set_pin(i, 1'h1);
        repeat (cyc) @(negedge mclk_i);
        act[i] = 1'h0;
    endtask : hold
    // ==========================================================
    // fan: two low-high pulses per revolution
    task automatic spin(input int revs);
        repeat (2 * revs) begin
            repeat (3) @(negedge mclk_i);
            tach_o = 1'h0;
            repeat (3) @(negedge mclk_i);
            tach_o = 1'h1;
        end
    endtask : spin
endmodule : spmgt_carrier

// [verif/tb_top.sv]
/*
 * tb_top: self-checking bench for spmgt_top with a short qualify count.
 * Assumes spmgt_carrier drives the asynchronous pins.
 */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [3:0] stim;
        logic [3:0] hold;
        logic [3:0] oc;
        logic exp;
    } spmgt_row_t;
    // stim, hold (0 = level), watched output, expected level
    localparam spmgt_row_t ROWS [9] = '{
        '{4'h4, 4'h0, 4'h0, 1'h0}, '{4'hA, 4'h0, 4'h0, 1'h0},
        '{4'hC, 4'h1, 4'h0, 1'h0}, '{4'hB, 4'h1, 4'h4, 1'h1},
        '{4'h7, 4'h0, 4'h9, 1'h1}, '{4'h8, 4'h0, 4'hA, 1'h1},
        '{4'h9, 4'h0, 4'h6, 1'h0}, '{4'hD, 4'h0, 4'h5, 1'h0},
        '{4'h2, 4'hC, 4'h7, 1'h1}};
    logic mclk_i, rst_i, vin_low, wdog, sw_rst, sw_ram, sw_off, trip, clr;
    logic [7:0] duty;
    logic [9:0] pin_n;
    logic tach, pwm;
    logic [12:0] obs;
    logic [15:0] revs, r0;
    int fails, checks_done, cnt;
    // ==========================================================
    // instances
    spmgt_carrier spmgt_carrier_i (.mclk_i(mclk_i), .pin_n_o(pin_n),
        .tach_o(tach));
    spmgt_top #(.QUAL_CYC(8)) spmgt_top_i (.mclk_i(mclk_i), .rst_i(rst_i),
        .power_button_n_i(pin_n[0]), .reset_button_n_i(pin_n[1]),
        .lid_button_n_i(pin_n[2]), .doze_button_n_i(pin_n[3]),
        .supply_good_i(pin_n[4]), .vin_low_i(vin_low),
        .pcie_wake_request_n_i(pin_n[5]),
        .general_wake_request_n_i(pin_n[6]), .battery_low_n_i(pin_n[7]),
        .overtemp_in_n_i(pin_n[8]), .sysmgmt_bus_alert_n_i(pin_n[9]),
        .fan_speed_sense_i(tach), .watchdog_timeout_i(wdog),
        .sw_reset_req_i(sw_rst), .sw_sleep_ram_i(sw_ram),
        .sw_soft_off_i(sw_off), .cpu_thermal_trip_i(trip),
        .event_clear_i(clr), .fan_duty_i(duty),
        .carrier_reset_out_n_o(obs[0]), .suspend_warning_n_o(obs[1]),
        .suspend_ram_n_o(obs[2]), .suspend_disk_n_o(obs[3]),
        .soft_off_n_o(obs[12]), .watchdog_expired_out_o(obs[4]),
        .thermal_shutdown_out_n_o(obs[5]),
        .system_mgmt_interrupt_n_o(obs[6]), .fan_drive_pwm_o(pwm),
        .lid_event_o(obs[7]), .doze_event_o(obs[8]),
        .battery_low_o(obs[9]), .overtemp_o(obs[10]),
        .wake_event_o(obs[11]), .fan_revs_o(revs));
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end
    // ==========================================================
    // helpers
    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: %0h not %0h", $time, what, seen, exp);
        end
    endtask : check
    // bounded wait for an output level; running out ends the run
    task automatic wait_for(input int c, input logic v, input int bound);
        int n;
        n = 0;
        while (obs[c] !== v && n < bound) begin
            @(negedge mclk_i);
            n++;
        end
        check(obs[c], v, $sformatf("output %0d", c));
        if (obs[c] !== v) finish_test();
    endtask : wait_for
    task automatic drive(input int c, input logic v);
        if (c < 10) spmgt_carrier_i.set_pin(c, v);
        else begin
            @(negedge mclk_i);
            case (c)
                10: vin_low = v;
                11: wdog = v;
                12: sw_rst = v;
                13: trip = v;
                14: sw_ram = v;
                default: sw_off = v;
            endcase
        end
    endtask : drive
    task automatic pulse(input int c);
        drive(c, 1'h1);
        drive(c, 1'h0);
    endtask : pulse
    // ==========================================================
    // main sequence
    initial begin
        {vin_low, wdog, sw_rst, sw_ram, sw_off, trip, clr} = 7'h00;
        duty = 8'h00;
        fails = 0;
        checks_done = 0;
        rst_i = 1'h1;
        repeat (3) @(negedge mclk_i);
        check({obs[0], obs[2], obs[3], obs[12], pwm}, 5'h08, "reset");
        rst_i = 1'h0;
        $display("test reset done");
        spmgt_carrier_i.hold(0, 4);
        repeat (30) @(negedge mclk_i);
        check(obs[12], 1'h0, "short press");
        spmgt_carrier_i.hold(0, 12);
        wait_for(12, 1'h1, 40);
        wait_for(0, 1'h1, 300);
        $display("test power on done");
        foreach (ROWS[i]) begin
            drive(ROWS[i].stim, 1'h1);
            if (ROWS[i].hold != 0) begin
                repeat (ROWS[i].hold - 1) @(negedge mclk_i);
                drive(ROWS[i].stim, 1'h0);
            end
            wait_for(ROWS[i].oc, ROWS[i].exp, 40);
            drive(ROWS[i].stim, 1'h0);
            clr = 1'h1;
            @(negedge mclk_i);
            clr = 1'h0;
            wait_for(0, 1'h1, 300);
        end
        $display("test table done");
        fork
            spmgt_carrier_i.hold(1, 300);
        join_none
        wait_for(0, 1'h0, 40);
        wait_for(0, 1'h1, 200);
        check(pin_n[1], 1'h0, "button still held");
        repeat (200) @(negedge mclk_i);
        check(obs[0], 1'h1, "no second reset");
        $display("test reset button done");
        pulse(14);
        wait_for(1, 1'h0, 10);
        check(obs[2], 1'h1, "warning leads");
        wait_for(2, 1'h0, 150);
        spmgt_carrier_i.hold(5, 12);
        wait_for(2, 1'h1, 40);
        spmgt_carrier_i.hold(3, 12);
        wait_for(8, 1'h1, 40);
        wait_for(2, 1'h0, 200);
        clr = 1'h1;
        @(negedge mclk_i);
        clr = 1'h0;
        check(obs[11], 1'h0, "wake cleared");
        spmgt_carrier_i.hold(6, 12);
        wait_for(11, 1'h1, 40);
        wait_for(2, 1'h1, 40);
        pulse(15);
        wait_for(1, 1'h0, 10);
        wait_for(3, 1'h0, 150);
        check(obs[12], 1'h0, "soft off");
        spmgt_carrier_i.hold(0, 12);
        wait_for(12, 1'h1, 40);
        wait_for(0, 1'h1, 300);
        $display("test sleep done");
        duty = 8'h40;
        repeat (300) @(negedge mclk_i);
        cnt = 0;
        repeat (1024) begin
            @(negedge mclk_i);
            cnt += int'(pwm === 1'h1);
        end
        check(cnt >= 252 && cnt <= 260, 1'h1, "pwm duty");
        r0 = revs;
        spmgt_carrier_i.spin(5);
        repeat (10) @(negedge mclk_i);
        check(revs, r0 + 16'h0005, "fan revs");
        $display("test fan done");
        finish_test();
    end
endmodule : tb_top
